// *** hw/gpfs_blink.sv ***
// LED stretcher: holds the LED high while its level is high and for a blink time after.
// Assumes the blink count arrives from LED control logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module gpfs_blink
  import gpfs_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    trig_i,
  input  wire logic [GPFS_BLINK_W-1:0] blink_cycles_i,
  output logic                         led_o
);

  logic [GPFS_BLINK_W-1:0] cnt_r;

  // Reload on every trigger cycle, count down after it ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (trig_i) begin
      cnt_r <= blink_cycles_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // High during the trigger and while the stretch counter runs.
  assign led_o = trig_i || (cnt_r != '0);

endmodule
`default_nettype wire

// *** hw/gpfs_pkg.sv ***
// Package for the pin function select block: register map, mode fields and carriers.
// Assumes a single 200 MHz device clock and a classic Wishbone register port.
package gpfs_pkg;

  localparam int unsigned GPFS_NUM_PINS     = 9;
  localparam int unsigned GPFS_FIELD_W      = 3;
  localparam logic [7:0]  GPFS_MODE_OFFSET  = 8'h00;
  localparam logic [31:0] GPFS_MODE_RESET   = 32'h0000_0000;
  localparam int unsigned GPFS_MODE_USED_W  = 27;
  localparam logic [4:0]  GPFS_RSVD_VALUE   = 5'h00;
  localparam logic [31:0] GPFS_UNMAPPED_RD  = 32'h0000_0000;
  localparam int unsigned GPFS_BLINK_W      = 16;

  // Field positions: the low bit of pin n's field.
  localparam int unsigned GPFS_PIN0_LSB = 0;
  localparam int unsigned GPFS_PIN1_LSB = 3;
  localparam int unsigned GPFS_PIN2_LSB = 6;
  localparam int unsigned GPFS_PIN3_LSB = 9;
  localparam int unsigned GPFS_PIN4_LSB = 12;
  localparam int unsigned GPFS_PIN5_LSB = 15;
  localparam int unsigned GPFS_PIN6_LSB = 18;
  localparam int unsigned GPFS_PIN7_LSB = 21;
  localparam int unsigned GPFS_PIN8_LSB = 24;

  // Mode codes.
  localparam logic [2:0] GPFS_CODE_0 = 3'h0;
  localparam logic [2:0] GPFS_CODE_1 = 3'h1;
  localparam logic [2:0] GPFS_CODE_2 = 3'h2;

  // Transceiver state seen by the mux.
  typedef struct packed {
    logic tx_state;
    logic rx_state;
    logic rf_port1;
    logic rf_port2;
    logic irq;
  } gpfs_xcvr_t;

  // Events that start LED pulses.
  typedef struct packed {
    logic good_frame;
    logic sfd_detect;
    logic receiver_on;
    logic transmit_done;
  } gpfs_led_evt_t;

  // Plain GPIO drive for all pins.
  typedef struct packed {
    logic [GPFS_NUM_PINS-1:0] out_val;
    logic [GPFS_NUM_PINS-1:0] out_en;
  } gpfs_gpio_t;

endpackage

// *** hw/gpfs_top.sv ***
// Pin function multiplexer for nine multi-purpose pins of a radio transceiver.
// Assumes device clock clk_i at 200 MHz, synchronous reset, and the GPIO clocks
// already enabled by software before the mode register is changed.
`timescale 1ns/100ps
`default_nettype none
module gpfs_top
  import gpfs_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  input  wire gpfs_xcvr_t               xcvr_i,
  input  wire gpfs_led_evt_t            led_evt_i,
  input  wire logic [GPFS_BLINK_W-1:0]  blink_cycles_i,
  input  wire gpfs_gpio_t               gpio_i,
  input  wire logic [GPFS_NUM_PINS-1:0] pin_i,
  output logic [GPFS_NUM_PINS-1:0]      pin_o,
  output logic [GPFS_NUM_PINS-1:0]      pin_oe_o,
  output logic [GPFS_NUM_PINS-1:0]      pin_in_o,
  output logic                          sync_o
);

  logic [31:0]              mode;
  logic [GPFS_NUM_PINS-1:0] pin_s1_r;
  logic [GPFS_NUM_PINS-1:0] pin_s2_r;
  logic [3:0]               led;
  logic [GPFS_NUM_PINS-1:0] pin_nxt;
  logic [GPFS_NUM_PINS-1:0] oe_nxt;
  logic [GPFS_NUM_PINS-1:0] pin_r;
  logic [GPFS_NUM_PINS-1:0] oe_r;
  logic                     sync_r;

  // Extracts a pin's three-bit mode field.
  function automatic logic [2:0] field(input logic [31:0] m, input int unsigned lsb);
    field = m[lsb +: GPFS_FIELD_W];
  endfunction

  // Register port.
  gpfs_wb_reg u_reg (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (wb_cyc_i),
    .stb_i  (wb_stb_i),
    .we_i   (wb_we_i),
    .adr_i  (wb_adr_i),
    .sel_i  (wb_sel_i),
    .dat_i  (wb_dat_i),
    .dat_o  (wb_dat_o),
    .ack_o  (wb_ack_o),
    .mode_o (mode)
  );

  // LED stretchers: good frame, SFD, receiver on, transmit done.
  gpfs_blink u_led_good (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .trig_i         (led_evt_i.good_frame),
    .blink_cycles_i (blink_cycles_i),
    .led_o          (led[0])
  );
  gpfs_blink u_led_sfd (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .trig_i         (led_evt_i.sfd_detect),
    .blink_cycles_i (blink_cycles_i),
    .led_o          (led[1])
  );
  gpfs_blink u_led_rxon (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .trig_i         (led_evt_i.receiver_on),
    .blink_cycles_i (blink_cycles_i),
    .led_o          (led[2])
  );
  gpfs_blink u_led_txd (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .trig_i         (led_evt_i.transmit_done),
    .blink_cycles_i (blink_cycles_i),
    .led_o          (led[3])
  );

  // Two-stage synchroniser on the pin inputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Per-pin source selection; reserved codes leave the pin undriven.
  always_comb begin
    pin_nxt = gpio_i.out_val;
    oe_nxt  = '0;
    // Pin 0.
    unique case (field(mode, GPFS_PIN0_LSB))
      GPFS_CODE_0: oe_nxt[0] = gpio_i.out_en[0];
      GPFS_CODE_1: begin pin_nxt[0] = led[0]; oe_nxt[0] = 1'b1; end
      GPFS_CODE_2: begin pin_nxt[0] = xcvr_i.tx_state; oe_nxt[0] = 1'b1; end
      default:     pin_nxt[0] = 1'b0;
    endcase
    // Pin 1.
    unique case (field(mode, GPFS_PIN1_LSB))
      GPFS_CODE_0: oe_nxt[1] = gpio_i.out_en[1];
      GPFS_CODE_1: begin pin_nxt[1] = led[1]; oe_nxt[1] = 1'b1; end
      GPFS_CODE_2: begin pin_nxt[1] = xcvr_i.rx_state; oe_nxt[1] = 1'b1; end
      default:     pin_nxt[1] = 1'b0;
    endcase
    // Pin 2.
    unique case (field(mode, GPFS_PIN2_LSB))
      GPFS_CODE_0: oe_nxt[2] = gpio_i.out_en[2];
      GPFS_CODE_1: begin pin_nxt[2] = led[2]; oe_nxt[2] = 1'b1; end
      GPFS_CODE_2: begin pin_nxt[2] = xcvr_i.rf_port1; oe_nxt[2] = 1'b1; end
      default:     pin_nxt[2] = 1'b0;
    endcase
    // Pin 3.
    unique case (field(mode, GPFS_PIN3_LSB))
      GPFS_CODE_0: oe_nxt[3] = gpio_i.out_en[3];
      GPFS_CODE_1: begin pin_nxt[3] = led[3]; oe_nxt[3] = 1'b1; end
      GPFS_CODE_2: begin pin_nxt[3] = xcvr_i.rf_port2; oe_nxt[3] = 1'b1; end
      default:     pin_nxt[3] = 1'b0;
    endcase
    // Pin 4.
    unique case (field(mode, GPFS_PIN4_LSB))
      GPFS_CODE_0: oe_nxt[4] = gpio_i.out_en[4];
      GPFS_CODE_1: begin pin_nxt[4] = xcvr_i.tx_state; oe_nxt[4] = 1'b1; end
      GPFS_CODE_2: begin pin_nxt[4] = xcvr_i.irq; oe_nxt[4] = 1'b1; end
      default:     pin_nxt[4] = 1'b0;
    endcase
    // Pin 5.
    unique case (field(mode, GPFS_PIN5_LSB))
      GPFS_CODE_0: oe_nxt[5] = gpio_i.out_en[5];
      GPFS_CODE_1: begin pin_nxt[5] = xcvr_i.tx_state; oe_nxt[5] = 1'b1; end
      default:     pin_nxt[5] = 1'b0;
    endcase
    // Pin 6.
    unique case (field(mode, GPFS_PIN6_LSB))
      GPFS_CODE_0: oe_nxt[6] = gpio_i.out_en[6];
      GPFS_CODE_1: begin pin_nxt[6] = xcvr_i.rx_state; oe_nxt[6] = 1'b1; end
      default:     pin_nxt[6] = 1'b0;
    endcase
    // Pin 7: reset code makes it the sync input, never driven.
    unique case (field(mode, GPFS_PIN7_LSB))
      GPFS_CODE_0: pin_nxt[7] = 1'b0;
      GPFS_CODE_1: oe_nxt[7] = gpio_i.out_en[7];
      default:     pin_nxt[7] = 1'b0;
    endcase
    // Pin 8: reset code makes it the interrupt request output.
    unique case (field(mode, GPFS_PIN8_LSB))
      GPFS_CODE_0: begin pin_nxt[8] = xcvr_i.irq; oe_nxt[8] = 1'b1; end
      GPFS_CODE_1: oe_nxt[8] = gpio_i.out_en[8];
      default:     pin_nxt[8] = 1'b0;
    endcase
  end

  // Registered pin drive.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_r <= '0;
      oe_r  <= '0;
    end else begin
      pin_r <= pin_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Sync test input routed out only while pin 7 is in its reset mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 1'b0;
    end else begin
      sync_r <= (field(mode, GPFS_PIN7_LSB) == GPFS_CODE_0) && pin_s2_r[7];
    end
  end

  assign pin_o    = pin_r;
  assign pin_oe_o = oe_r;
  assign pin_in_o = pin_s2_r;
  assign sync_o   = sync_r;

  // Checks.
  sequence wr_mode_s;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_adr_i == GPFS_MODE_OFFSET)
      && (wb_sel_i == 4'hf);
  endsequence

  mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode_s |=> (mode[GPFS_MODE_USED_W-1:0] == $past(wb_dat_i[GPFS_MODE_USED_W-1:0])))
    else $error("mode write not stored");

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode[31:GPFS_MODE_USED_W] == GPFS_RSVD_VALUE)
    else $error("reserved mode bits not zero");

  sw0_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN0_LSB) == GPFS_CODE_2) |=> (pin_o[0] == $past(xcvr_i.tx_state)))
    else $error("pin 0 antenna switch wrong");

  sw1_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN1_LSB) == GPFS_CODE_2) |=> (pin_o[1] == $past(xcvr_i.rx_state)))
    else $error("pin 1 antenna switch wrong");

  sw2_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN2_LSB) == GPFS_CODE_2) |=> (pin_o[2] == $past(xcvr_i.rf_port1)))
    else $error("pin 2 antenna switch wrong");

  sw3_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN3_LSB) == GPFS_CODE_2) |=> (pin_o[3] == $past(xcvr_i.rf_port2)))
    else $error("pin 3 antenna switch wrong");

  sfd_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (led_evt_i.sfd_detect && (field(mode, GPFS_PIN1_LSB) == GPFS_CODE_1)) |=> pin_o[1])
    else $error("sfd led not lit");

  rxon_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(led_evt_i.receiver_on) && (blink_cycles_i != '0)) |-> led[2])
    else $error("receiver led not stretched");

  txd_led_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (led_evt_i.transmit_done && (field(mode, GPFS_PIN3_LSB) == GPFS_CODE_1)) |=> pin_o[3])
    else $error("transmit done led not lit");

  amp_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN4_LSB) == GPFS_CODE_1) |=> (pin_o[4] == $past(xcvr_i.tx_state)))
    else $error("amplifier enable wrong");

  ext_txe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN5_LSB) == GPFS_CODE_1) |=> (pin_oe_o[5] && pin_o[5] == $past(xcvr_i.tx_state)))
    else $error("external transmit enable wrong");

  ext_rxe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN6_LSB) == GPFS_CODE_1) |=> (pin_oe_o[6] && pin_o[6] == $past(xcvr_i.rx_state)))
    else $error("external receive enable wrong");

  sync_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (field(mode, GPFS_PIN7_LSB) == GPFS_CODE_0) |=> !pin_oe_o[7])
    else $error("sync pin driven");

  irq_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && (field(mode, GPFS_PIN8_LSB) == GPFS_CODE_0))
      |=> (pin_oe_o[8] && pin_o[8] == $past(xcvr_i.irq)))
    else $error("interrupt pin wrong");

endmodule
`default_nettype wire

// *** hw/gpfs_wb_reg.sv ***
// Wishbone classic slave holding the pin function select register.
// Assumes a classic single-cycle master on the device clock.
`timescale 1ns/100ps
`default_nettype none
module gpfs_wb_reg
  import gpfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic [31:0]      mode_o
);

  logic        ack_r;
  logic [31:0] mode_r;
  logic [31:0] dat_r;
  logic        req;
  logic        hit;

  assign req = cyc_i && stb_i && !ack_r;
  assign hit = (adr_i == GPFS_MODE_OFFSET);

  // One-cycle acknowledge for every access, mapped or not.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Byte-lane writes; the reserved top bits never store.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= GPFS_MODE_RESET;
    end else if (req && we_i && hit) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          mode_r[b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
      mode_r[31:GPFS_MODE_USED_W] <= GPFS_RSVD_VALUE;
    end
  end

  // Read data captured with the acknowledge; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (req && !we_i) begin
      dat_r <= hit ? mode_r : GPFS_UNMAPPED_RD;
    end
  end

  assign ack_o  = ack_r;
  assign dat_o  = dat_r;
  assign mode_o = mode_r;

endmodule
`default_nettype wire

// *** verification/gpfs_far_model.sv ***
// Far-side model: the LEDs, antenna switches and amplifier enables on the nine pins.
// Assumes the bench gives a drive level for any pin that is used as an input.
`timescale 1ns/100ps
`default_nettype none
module gpfs_far_model
  import gpfs_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [GPFS_NUM_PINS-1:0] pin_val_i,
  input  wire logic [GPFS_NUM_PINS-1:0] pin_oe_i,
  input  wire logic [GPFS_NUM_PINS-1:0] drv_val_i,
  input  wire logic [GPFS_NUM_PINS-1:0] drv_en_i,
  output logic [GPFS_NUM_PINS-1:0]      wire_o
);
  logic [GPFS_NUM_PINS-1:0] last_r;

  // Remembers the wire so that a released pin never shows a stale level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_r <= '0;
    end else begin
      last_r <= wire_o;
    end
  end

  // The device drive wins, then the external driver; a floating pin toggles.
  always_comb begin
    for (int k = 0; k < GPFS_NUM_PINS; k++) begin
      wire_o[k] = pin_oe_i[k] ? pin_val_i[k] : (drv_en_i[k] ? drv_val_i[k] : ~last_r[k]);
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_gpio_pin_function_select.sv ***
// Testbench for the pin function select block: register port, pin modes, LED stretch.
// Assumes one 200 MHz clock and the far-side model on the pins.
`timescale 1ns/100ps
`default_nettype none
module tb_gpio_pin_function_select
  import gpfs_pkg::*;
;
  logic          clk_i, rst_i, cyc, stb, we, ack, sync;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat, q;
  logic [15:0]   blink;
  logic [8:0]    pin_o, pin_oe, pin_in, pin_i, drv_val, drv_en;
  gpfs_xcvr_t    xcvr;
  gpfs_led_evt_t evt;
  gpfs_gpio_t    gpio;
  int            num_errors, compares;
  int            cnt [4];

  gpfs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .xcvr_i(xcvr), .led_evt_i(evt), .blink_cycles_i(blink),
    .gpio_i(gpio), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_in_o(pin_in),
    .sync_o(sync));
  gpfs_far_model far_u (.clk_i(clk_i), .rst_i(rst_i), .pin_val_i(pin_o),
    .pin_oe_i(pin_oe), .drv_val_i(drv_val), .drv_en_i(drv_en), .wire_o(pin_i));

  // Free-running device clock.
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic bus cycle, held until ack is sampled; read data lands in q.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    chk("bus ack", 32'h0000_0001, 32'(ack));
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask

  // Reads a register and compares it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 4'hF, 32'h0000_0000);
    chk("register read", e, q);
  endtask

  // Lets the pins settle, then compares drive enables and driven values.
  task automatic pins(input logic [8:0] ev, input logic [8:0] eo);
    repeat (4) @(posedge clk_i);
    chk("pin enable", 32'(eo), 32'(pin_oe));
    chk("pin value", 32'(ev), 32'(pin_o & pin_oe));
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    final_report();
  end

  // Main sequence.
  initial begin
    rst_i = 1'h1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    {xcvr, evt, gpio, drv_val, drv_en} = '0;
    blink = 16'h0004;
    num_errors = 0;
    compares = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    gpio <= {9'h0AA, 9'h07F};
    drv_en <= 9'h080;
    for (int k = 0; k < 2; k++) begin
      xcvr <= 5'(k);
      drv_val <= 9'(k << 7);
      pins(9'h02A | 9'(k << 8), 9'h17F);
      chk("sync input", 32'(k), 32'(sync));
      chk("pin input", 32'(k), 32'(pin_in[7]));
    end
    rd(GPFS_MODE_OFFSET, GPFS_MODE_RESET);
    // Pins 0 to 6 in their state or switch modes, pins 7 and 8 as GPIO; reserved top bits written high.
    wb(1'h1, GPFS_MODE_OFFSET, 4'hF, 32'hF924_9492);
    rd(GPFS_MODE_OFFSET, 32'h0124_9492);
    gpio <= {9'h155, 9'h180};
    drv_en <= 9'h000;
    for (int v = 0; v < 16; v++) begin
      xcvr <= {4'(v), 1'h0};
      pins({2'h2, v[2], v[3], v[3], v[0], v[1], v[2], v[3]}, 9'h1FF);
    end
    // Byte lanes other than the lowest leave the low byte untouched.
    wb(1'h1, GPFS_MODE_OFFSET, 4'hE, 32'h0000_0000);
    rd(GPFS_MODE_OFFSET, 32'h0000_0092);
    wb(1'h1, GPFS_MODE_OFFSET, 4'hF, 32'h0000_2000);
    gpio <= '0;
    xcvr <= 5'h01;
    pins(9'h110, 9'h110);
    wb(1'h1, 8'h04, 4'hF, 32'h0000_0249);
    rd(8'h04, GPFS_UNMAPPED_RD);
    rd(GPFS_MODE_OFFSET, 32'h0000_2000);
    // LED modes on pins 0 to 3, stretch measured for two blink lengths.
    wb(1'h1, GPFS_MODE_OFFSET, 4'hF, 32'h0000_0249);
    for (int b = 1; b < 5; b += 3) begin
      blink <= 16'(b);
      @(posedge clk_i);
      evt <= 4'hF;
      cnt = '{default: 0};
      for (int i = 0; i < 24; i++) begin
        @(posedge clk_i);
        for (int p = 0; p < 4; p++) cnt[p] += int'(pin_o[p] === 1'h1);
        if (i == 0) evt <= 4'h2;
        if (i == 2) evt <= 4'h0;
      end
      chk("good frame led", 32'(b + 1), 32'(cnt[0]));
      chk("sfd led", 32'(b + 1), 32'(cnt[1]));
      chk("receiver led", 32'(b + 3), 32'(cnt[2]));
      chk("transmit led", 32'(b + 1), 32'(cnt[3]));
      chk("led enable", 32'h0000_000F, 32'(pin_oe[3:0]));
    end
    // A second reset in mid-run restores the register.
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(GPFS_MODE_OFFSET, GPFS_MODE_RESET);
    final_report();
  end
endmodule
`default_nettype wire
